// [design/pcuhi_card.sv]
// card end: host strobe decode, attribute memory, uart modem regs
// assumes link inputs synchronous to CLK; RST_N async, active low
`timescale 1ns/1ps
//Contract
// - ten-bit address: attribute, card io, com port
// - eight-bit data bus driven only on reads
// - input acknowledge low on decoded io read
// - io read needs iord, reg, card enable
// - io write needs iowr, reg, card enable
// - ireq requests service; shows ready before configuration
// - host even-byte attribute write raises subsystem interrupt
// - user outputs follow modem control bits two, three outside loop mode
// - receiver runs from sixteen-times receiver clock
// - subsystem read: enable or data strobe by mode
// - reg low routes strobes; no common memory
// - attribute read data driven only while oe low
// - master reset clears uart and configuration
// - ring level and trailing ring edge in status
// - card enables select even, odd bytes
module pcuhi_card #(
   parameter int INIT_CYC = pcuhi_pkg::INIT_CYCLES,
   parameter logic [6:0] COM_ADDR = pcuhi_pkg::COM_BASE
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   pcuhi_if.card BUS,
   input wire logic RING_INDICATOR_N,
   input wire logic RCLK,
   input wire logic SUBSYS_READ_STROBE_N,
   input wire logic SUBSYS_ZMODE,
   input wire logic SUBSYS_RW,
   input wire logic [7:0] SUBSYS_ADDR,
   output logic [7:0] SUBSYS_DATA,
   output logic SUB_IRQ,
   output logic USER_OUTPUT_A_N,
   output logic USER_OUTPUT_B_N,
   output logic RX_SAMPLE_TICK
);
   logic [7:0] attr_mem [pcuhi_pkg::ATTR_DEPTH];
   logic [1:0] cfg;
   logic [4:0] init_cnt;
   logic ready;
   logic [7:0] ier;
   logic [7:0] modem_control_reg;
   logic [7:0] scr;
   logic trailing_edge_ring_flag;
   logic ring_q;
   logic attr_wr_q;
   logic io_rd_q;
   logic io_wr_q;
   logic sub_rd_q;

   // byte select from card enables and low address bit
   wire sel = ~BUS.ce1_n | ~BUS.ce2_n;
   wire a0 = BUS.ce1_n ? 1'b1 : BUS.host_addr[0];
   wire [9:0] eff_addr = {BUS.host_addr[9:1], a0};
   wire [7:0] attr_idx = eff_addr[8:1];
   wire attr_even = ~eff_addr[0];
   wire [2:0] ur_off = eff_addr[2:0];

   // strobe qualification: reg low steers oe/we or iord/iowr
   wire attr_rd = ~BUS.reg_n & ~BUS.oe_n & sel;
   wire attr_wr = ~BUS.reg_n & ~BUS.we_n & sel;
   wire io_rd = ~BUS.reg_n & ~BUS.iord_n & sel;
   wire io_wr = ~BUS.reg_n & ~BUS.iowr_n & sel;
   wire mreset = BUS.card_reset;

   // io decode depends on configuration mode
   wire io_hit = (cfg == pcuhi_pkg::CFG_CARD_IO) |
                 ((cfg == pcuhi_pkg::CFG_COM) &
                  (eff_addr[9:3] == COM_ADDR));
   wire io_rd_hit = io_rd & io_hit;
   wire attr_wr_go = attr_wr & ~attr_wr_q & attr_even;
   wire io_wr_go = io_wr & ~io_wr_q & io_hit;
   wire io_rd_go = io_rd_hit & ~io_rd_q;
   // io read data frozen after the leading edge of the strobe
   wire hold_rd = io_rd_hit & io_rd_q;

   // modem status and interrupt terms
   wire ring_rise = RING_INDICATOR_N & ~ring_q;
   wire msr_rd = io_rd_go & (ur_off == pcuhi_pkg::UR_MSR);
   wire [7:0] modem_status_reg = {1'b0, ~ring_q, 3'h0, trailing_edge_ring_flag,
                     2'h0};
   wire uart_irq = ier[pcuhi_pkg::IER_MSI] & trailing_edge_ring_flag;
   wire loop = modem_control_reg[pcuhi_pkg::MCR_LOOP];

   // uart read selection
   wire [7:0] ur_rdata =
      (ur_off == pcuhi_pkg::UR_IER) ? ier :
      (ur_off == pcuhi_pkg::UR_MCR) ? modem_control_reg :
      (ur_off == pcuhi_pkg::UR_MSR) ? modem_status_reg :
      (ur_off == pcuhi_pkg::UR_SCR) ? scr : 8'h00;
   wire [7:0] attr_rdata = attr_even ? attr_mem[attr_idx] :
                           pcuhi_pkg::IDLE_DATA;

   // subsystem read qualified by bus mode
   wire sub_rd = SUBSYS_ZMODE ? (~SUBSYS_READ_STROBE_N & SUBSYS_RW) :
                 ~SUBSYS_READ_STROBE_N;
   wire sub_rd_go = sub_rd & ~sub_rd_q;

   // attribute memory store, no reset needed
   always_ff @(posedge CLK) begin
      if (CLK_EN && attr_wr_go) begin
         attr_mem[attr_idx] <= BUS.host_data;
      end
   end

   // strobe history for leading-edge detection
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         attr_wr_q <= 1'b0;
         io_rd_q <= 1'b0;
         io_wr_q <= 1'b0;
         sub_rd_q <= 1'b0;
         ring_q <= 1'b1;
      end else if (CLK_EN) begin
         attr_wr_q <= attr_wr;
         io_rd_q <= io_rd_hit;
         io_wr_q <= io_wr;
         sub_rd_q <= sub_rd;
         ring_q <= RING_INDICATOR_N;
      end
   end

   // configuration and busy period after reset
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg <= pcuhi_pkg::CFG_NONE;
         init_cnt <= 5'h00;
         ready <= 1'b0;
      end else if (CLK_EN) begin
         if (mreset) begin
            cfg <= pcuhi_pkg::CFG_NONE;
            init_cnt <= 5'h00;
            ready <= 1'b0;
         end else begin
            if (init_cnt == 5'(INIT_CYC - 1)) begin
               ready <= 1'b1;
            end else begin
               init_cnt <= init_cnt + 5'h01;
            end
            if (attr_wr_go && attr_idx == pcuhi_pkg::ATTR_COR_IDX) begin
               cfg <= BUS.host_data[1:0];
            end
         end
      end
   end

   // uart registers written from io space
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ier <= pcuhi_pkg::UR_RST;
         modem_control_reg <= pcuhi_pkg::UR_RST;
         scr <= pcuhi_pkg::UR_RST;
      end else if (CLK_EN) begin
         if (mreset) begin
            ier <= pcuhi_pkg::UR_RST;
            modem_control_reg <= pcuhi_pkg::UR_RST;
            scr <= pcuhi_pkg::UR_RST;
         end else if (io_wr_go) begin
            if (ur_off == pcuhi_pkg::UR_IER) ier <= BUS.host_data;
            if (ur_off == pcuhi_pkg::UR_MCR) modem_control_reg <= BUS.host_data;
            if (ur_off == pcuhi_pkg::UR_SCR) scr <= BUS.host_data;
         end
      end
   end

   // trailing ring flag: a new edge beats a clearing read
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         trailing_edge_ring_flag <= 1'b0;
      end else if (CLK_EN) begin
         if (mreset) begin
            trailing_edge_ring_flag <= 1'b0;
         end else if (ring_rise) begin
            trailing_edge_ring_flag <= 1'b1;
         end else if (msr_rd) begin
            trailing_edge_ring_flag <= 1'b0;
         end
      end
   end

   // subsystem interrupt and subsystem read port
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         SUB_IRQ <= 1'b0;
         SUBSYS_DATA <= 8'h00;
      end else if (CLK_EN) begin
         if (attr_wr_go) begin
            SUB_IRQ <= 1'b1;
         end else if (sub_rd_go || mreset) begin
            SUB_IRQ <= 1'b0;
         end
         if (sub_rd_go) begin
            SUBSYS_DATA <= attr_mem[SUBSYS_ADDR];
         end
      end
   end

   // host side outputs, all registered
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         BUS.card_dout <= 8'h00;
         BUS.card_doe <= 1'b0;
         BUS.inpack_n <= 1'b1;
         BUS.ireq_n <= 1'b0;
         USER_OUTPUT_A_N <= 1'b1;
         USER_OUTPUT_B_N <= 1'b1;
      end else if (CLK_EN) begin
         BUS.card_doe <= (attr_rd & attr_even) | io_rd_hit;
         // a clearing status read must still return the flag it clears
         if (!hold_rd) begin
            BUS.card_dout <= attr_rd ? attr_rdata : ur_rdata;
         end
         BUS.inpack_n <= ~io_rd_hit;
         // busy at once under master reset, not one edge late
         BUS.ireq_n <= ~mreset &
                       ((cfg == pcuhi_pkg::CFG_NONE) ? ready :
                        ~uart_irq);
         USER_OUTPUT_A_N <= mreset | loop |
                            ~modem_control_reg[pcuhi_pkg::MCR_OUTA];
         USER_OUTPUT_B_N <= mreset | loop |
                            ~modem_control_reg[pcuhi_pkg::MCR_OUTB];
      end
   end

   // receiver sample tick from the 16x clock
   pcuhi_rx_tick #(
      .DIV(pcuhi_pkg::RCLK_DIV)
   ) u_rx_tick (
      .CLK(CLK),
      .RST_N(RST_N),
      .CLK_EN(CLK_EN),
      .CLR(mreset),
      .RCLK(RCLK),
      .TICK(RX_SAMPLE_TICK)
   );
endmodule

// [shared/pcuhi_pkg.sv]
// constants shared by the card end, the host end and the bench
// assumes a single 50 MHz clock on both ends
package pcuhi_pkg;
   // link widths
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int ATTR_DEPTH = 256;
   // uart register offsets in card i/o space
   localparam logic [2:0] UR_IER = 3'h1;
   localparam logic [2:0] UR_MCR = 3'h4;
   localparam logic [2:0] UR_MSR = 3'h6;
   localparam logic [2:0] UR_SCR = 3'h7;
   // uart field positions
   localparam int IER_MSI = 3;
   localparam int MCR_OUTA = 2;
   localparam int MCR_OUTB = 3;
   localparam int MCR_LOOP = 4;
   localparam int MSR_TRAILING_EDGE_RING_FLAG = 2;
   localparam int MSR_RI = 6;
   localparam logic [7:0] UR_RST = 8'h00;
   localparam logic [7:0] IDLE_DATA = 8'hFF;
   // configuration option byte in attribute memory
   localparam logic [7:0] ATTR_COR_IDX = 8'h80;
   localparam logic [1:0] CFG_NONE = 2'h0;
   localparam logic [1:0] CFG_CARD_IO = 2'h1;
   localparam logic [1:0] CFG_COM = 2'h2;
   localparam logic [6:0] COM_BASE = 7'h7F;
   // card busy time after reset, receiver clock ratio
   localparam int INIT_CYCLES = 16;
   localparam int RCLK_DIV = 16;
   // host strobe timing
   localparam int CLK_NS = 20;
   localparam int STROBE_NS = 100;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   // host controller register map
   localparam logic [2:0] H_ADDR_LO = 3'h0;
   localparam logic [2:0] H_DATA = 3'h1;
   localparam logic [2:0] H_CMD = 3'h2;
   localparam logic [2:0] H_STAT = 3'h3;
   localparam logic [2:0] H_CTRL = 3'h4;
   localparam logic [2:0] H_ADDR_HI = 3'h5;
   localparam int ST_BUSY = 0;
   localparam int ST_ACK = 1;
   localparam int ST_IREQ = 2;
   localparam int CT_RESET = 0;
   localparam int CT_ODD = 1;
   typedef enum logic [1:0] {
      CMD_ATTR_RD, CMD_ATTR_WR, CMD_IO_RD, CMD_IO_WR
   } pcuhi_cmd_e;
endpackage

// [shared/pcuhi_if.sv]
// pc card link between host controller and serial card
// assumes both ends share one clock; data bus idles high
`timescale 1ns/1ps
interface pcuhi_if;
   logic [9:0] host_addr;
   logic [7:0] host_dout;
   logic host_doe;
   logic [7:0] card_dout;
   logic card_doe;
   logic [7:0] host_data;
   logic ce1_n;
   logic ce2_n;
   logic reg_n;
   logic oe_n;
   logic we_n;
   logic iord_n;
   logic iowr_n;
   logic card_reset;
   logic inpack_n;
   logic ireq_n;
   // resolved level of the shared data bus, pulled up when idle
   assign host_data = card_doe ? card_dout :
                      (host_doe ? host_dout : 8'hFF);
   modport card (
      input host_addr, host_data, ce1_n, ce2_n, reg_n, oe_n, we_n,
      input iord_n, iowr_n, card_reset,
      output card_dout, card_doe, inpack_n, ireq_n
   );
   modport host (
      output host_addr, host_dout, host_doe, ce1_n, ce2_n, reg_n,
      output oe_n, we_n, iord_n, iowr_n, card_reset,
      input host_data, inpack_n, ireq_n
   );
endinterface

// [design/pcuhi_rx_tick.sv]
// receiver sample tick from the 16x receiver clock input
// assumes the receiver clock is slower than half of CLK
`timescale 1ns/1ps
module pcuhi_rx_tick #(
   parameter int DIV = pcuhi_pkg::RCLK_DIV
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   input wire logic CLR,
   input wire logic RCLK,
   output logic TICK
);
   logic rclk_q;
   logic [4:0] cnt;
   wire rise = RCLK & ~rclk_q;
   wire last = cnt == 5'(DIV - 1);

   // one tick per sixteen receiver clock rising edges
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rclk_q <= 1'b0;
         cnt <= 5'h00;
         TICK <= 1'b0;
      end else if (CLK_EN) begin
         rclk_q <= RCLK;
         TICK <= rise & last & ~CLR;
         if (CLR) begin
            cnt <= 5'h00;
         end else if (rise) begin
            cnt <= last ? 5'h00 : cnt + 5'h01;
         end
      end
   end
endmodule

// [design/pcuhi_host.sv]
// host end: runs one pc card cycle per command register write made while idle
// assumes software port synchronous to CLK; RST_N async, active low
`timescale 1ns/1ps
module pcuhi_host #(
   parameter int STROBE_CYC = pcuhi_pkg::STROBE_CYC
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   pcuhi_if.host BUS,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA
);
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER}
      pcuhi_state_e;
   pcuhi_state_e state;
   pcuhi_pkg::pcuhi_cmd_e cmd;
   logic [9:0] addr;
   logic [7:0] data;
   logic [1:0] ctrl;
   logic ack;
   logic [2:0] cnt;

   wire busy = state != ST_IDLE;
   wire cmd_go = WR & (ADDR == pcuhi_pkg::H_CMD) & ~busy;
   wire is_wr = (cmd == pcuhi_pkg::CMD_ATTR_WR) |
                (cmd == pcuhi_pkg::CMD_IO_WR);
   wire strobe_end = cnt == 3'(STROBE_CYC - 1);
   wire [7:0] stat = {5'h00, ~BUS.ireq_n, ack, busy};
   wire [7:0] rmux =
      (ADDR == pcuhi_pkg::H_ADDR_LO) ? addr[7:0] :
      (ADDR == pcuhi_pkg::H_ADDR_HI) ? {6'h00, addr[9:8]} :
      (ADDR == pcuhi_pkg::H_DATA) ? data :
      (ADDR == pcuhi_pkg::H_STAT) ? stat :
      (ADDR == pcuhi_pkg::H_CTRL) ? {6'h00, ctrl} : 8'h00;

   // software registers and read port
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         addr <= 10'h000;
         ctrl <= 2'h0;
         RDATA <= 8'h00;
      end else if (CLK_EN) begin
         RDATA <= RD ? rmux : 8'h00;
         if (WR && ADDR == pcuhi_pkg::H_ADDR_LO) addr[7:0] <= WDATA;
         if (WR && ADDR == pcuhi_pkg::H_ADDR_HI) addr[9:8] <= WDATA[1:0];
         if (WR && ADDR == pcuhi_pkg::H_CTRL) ctrl <= WDATA[1:0];
      end
   end

   // cycle sequencer: setup, strobe, recover
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= ST_IDLE;
         cmd <= pcuhi_pkg::CMD_ATTR_RD;
         data <= 8'h00;
         ack <= 1'b0;
         cnt <= 3'h0;
      end else if (CLK_EN) begin
         unique case (state)
            ST_IDLE: begin
               if (WR && ADDR == pcuhi_pkg::H_DATA) data <= WDATA;
               if (cmd_go) begin
                  cmd <= pcuhi_pkg::pcuhi_cmd_e'(WDATA[1:0]);
                  ack <= 1'b0;
                  state <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               cnt <= 3'h0;
               state <= ST_STROBE;
            end
            ST_STROBE: begin
               cnt <= cnt + 3'h1;
               if (!BUS.inpack_n) ack <= 1'b1;
               if (strobe_end) begin
                  if (!is_wr) data <= BUS.host_data;
                  state <= ST_RECOVER;
               end
            end
            ST_RECOVER: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // link outputs, all registered; reg stays low through the cycle
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         BUS.host_addr <= 10'h000;
         BUS.host_dout <= 8'h00;
         BUS.host_doe <= 1'b0;
         BUS.ce1_n <= 1'b1;
         BUS.ce2_n <= 1'b1;
         BUS.reg_n <= 1'b1;
         BUS.oe_n <= 1'b1;
         BUS.we_n <= 1'b1;
         BUS.iord_n <= 1'b1;
         BUS.iowr_n <= 1'b1;
         BUS.card_reset <= 1'b1;
      end else if (CLK_EN) begin
         BUS.card_reset <= ctrl[pcuhi_pkg::CT_RESET];
         BUS.host_addr <= addr;
         BUS.host_dout <= data;
         BUS.host_doe <= busy & is_wr;
         BUS.ce1_n <= ~busy | ctrl[pcuhi_pkg::CT_ODD];
         BUS.ce2_n <= ~busy | ~ctrl[pcuhi_pkg::CT_ODD];
         BUS.reg_n <= ~busy;
         BUS.oe_n <= ~(state == ST_SETUP || (state == ST_STROBE &&
                   !strobe_end)) | (cmd != pcuhi_pkg::CMD_ATTR_RD);
         BUS.we_n <= ~(state == ST_SETUP || (state == ST_STROBE &&
                   !strobe_end)) | (cmd != pcuhi_pkg::CMD_ATTR_WR);
         BUS.iord_n <= ~(state == ST_SETUP || (state == ST_STROBE &&
                     !strobe_end)) | (cmd != pcuhi_pkg::CMD_IO_RD);
         BUS.iowr_n <= ~(state == ST_SETUP || (state == ST_STROBE &&
                     !strobe_end)) | (cmd != pcuhi_pkg::CMD_IO_WR);
      end
   end
endmodule

// [bench/pcuhi_link_sva.sv]
// checker for the pc card link between host end and card end
// assumes one clock domain and the link signals wired in as plain inputs
`timescale 1ns/1ps
module pcuhi_link_sva #(
   parameter int INIT_CYC = 16
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [9:0] host_addr,
   input wire logic ce1_n,
   input wire logic ce2_n,
   input wire logic reg_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic iord_n,
   input wire logic iowr_n,
   input wire logic card_reset,
   input wire logic card_doe,
   input wire logic inpack_n,
   input wire logic ireq_n
);
   localparam int INIT_HI = INIT_CYC + 8;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // qualified strobes seen by the card
   wire sel = !reg_n && !(ce1_n && ce2_n);
   wire io_rd_q = !iord_n && sel;
   wire rd_any = sel && (!oe_n || !iord_n);
   // start of an even attribute read, and an acknowledged io read
   sequence attr_rd_start;
      $fell(oe_n) && sel && !ce1_n && !host_addr[0];
   endsequence
   sequence io_ack;
      !iord_n && !inpack_n;
   endsequence
   chk_ack_io_read: assert property (!inpack_n |-> $past(io_rd_q))
      else $error("acknowledge without a qualified io read");
   chk_drive_on_read: assert property (card_doe |-> $past(rd_any))
      else $error("card drives data outside a read");
   chk_oe_gates_data: assert property (attr_rd_start |=> card_doe[*3])
      else $error("attribute read data not driven while oe low");
   chk_oe_release: assert property ($rose(oe_n) |=> !card_doe)
      else $error("card still drives data after oe rose");
   chk_write_no_drive: assert property
      ((!we_n || !iowr_n) |-> !card_doe)
      else $error("card drives data during a write");
   chk_ack_stands: assert property (io_ack ##1 !iord_n |-> !inpack_n)
      else $error("acknowledge dropped while io read held");
   chk_ack_release: assert property ($rose(iord_n) |=> inpack_n)
      else $error("acknowledge held after io read ended");
   chk_reset_busy: assert property
      (card_reset |=> !ireq_n && inpack_n && !card_doe)
      else $error("card not busy and quiet under reset");
   chk_ready_after_init: assert property
      ($fell(card_reset) |-> !ireq_n ##[1:INIT_HI] ireq_n)
      else $error("card never reported ready after reset");
endmodule

// [bench/pc_card_uart_host_interface_tb.sv]
// self-checking bench: host end and card end joined by the link
// assumes 50 MHz clock; software port and subsystem driven on rising edge
`timescale 1ns/1ps
module pc_card_uart_host_interface_tb;
   localparam int INIT_CYC = 4;
   logic CLK = 0;
   logic RST_N = 0;
   logic [2:0] adr = 0;
   logic [7:0] wdat = 0;
   logic wr = 0;
   logic rd = 0;
   logic [7:0] rdat;
   logic ring_n = 1;
   logic rclk = 0;
   logic sub_rd_n = 1;
   logic zmode = 0;
   logic sub_rw = 1;
   logic [7:0] sub_addr = 0;
   logic [7:0] sub_data;
   logic sub_irq;
   logic out_a_n;
   logic out_b_n;
   logic tick;
   logic [7:0] q;
   logic [7:0] d;
   logic ack;
   int bad_count = 0;
   int checks = 0;
   int seed = 6966;
   int cyc = 0;
   int ticks = 0;
   int i;
   int attr_m[256];
   int mcr_m;
   int scr_m;
   pcuhi_if bus();
   pcuhi_card #(.INIT_CYC(INIT_CYC)) i_pcuhi_card (.CLK(CLK), .RST_N(RST_N),
      .CLK_EN(1'b1), .BUS(bus.card), .RING_INDICATOR_N(ring_n), .RCLK(rclk),
      .SUBSYS_READ_STROBE_N(sub_rd_n), .SUBSYS_ZMODE(zmode),
      .SUBSYS_RW(sub_rw), .SUBSYS_ADDR(sub_addr), .SUBSYS_DATA(sub_data),
      .SUB_IRQ(sub_irq), .USER_OUTPUT_A_N(out_a_n),
      .USER_OUTPUT_B_N(out_b_n), .RX_SAMPLE_TICK(tick));
   pcuhi_host i_pcuhi_host (.CLK(CLK), .RST_N(RST_N), .CLK_EN(1'b1),
      .BUS(bus.host), .ADDR(adr), .WDATA(wdat), .WR(wr), .RD(rd),
      .RDATA(rdat));
   pcuhi_link_sva #(.INIT_CYC(INIT_CYC)) i_pcuhi_link_sva (.CLK(CLK),
      .RST_N(RST_N), .host_addr(bus.host_addr), .ce1_n(bus.ce1_n),
      .ce2_n(bus.ce2_n), .reg_n(bus.reg_n), .oe_n(bus.oe_n),
      .we_n(bus.we_n), .iord_n(bus.iord_n), .iowr_n(bus.iowr_n),
      .card_reset(bus.card_reset), .card_doe(bus.card_doe),
      .inpack_n(bus.inpack_n), .ireq_n(bus.ireq_n));
   // clock and hang guard
   always #10 CLK = ~CLK;
   always @(posedge CLK) begin
      cyc++;
      if (tick === 1'b1) ticks++;
      if (cyc == 60000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic tdone(input string n);
      $display("test %s done, checks %0d bad %0d", n, checks, bad_count);
   endtask
   // software port: one-cycle strobes, read data in the following cycle
   task automatic sw_wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge CLK);
      adr <= a;
      wdat <= v;
      wr <= 1;
      @(posedge CLK);
      wr <= 0;
   endtask
   task automatic sw_rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge CLK);
      adr <= a;
      rd <= 1;
      @(posedge CLK);
      rd <= 0;
      #1 v = rdat;
   endtask
   // one link cycle through the host end, waits for busy to clear
   task automatic op(input logic [9:0] a, input pcuhi_pkg::pcuhi_cmd_e c,
                     input logic [7:0] v);
      logic [7:0] st;
      int n;
      sw_wr(pcuhi_pkg::H_ADDR_LO, a[7:0]);
      sw_wr(pcuhi_pkg::H_ADDR_HI, {6'h0, a[9:8]});
      sw_wr(pcuhi_pkg::H_DATA, v);
      sw_wr(pcuhi_pkg::H_CMD, {6'h0, c});
      st = 8'h01;
      n = 0;
      while (st[0] !== 1'b0 && n < 40) begin
         sw_rd(pcuhi_pkg::H_STAT, st);
         n++;
      end
      chk(8'(st[0]), 8'h00, "host busy stuck");
      ack = st[1];
      sw_rd(pcuhi_pkg::H_DATA, q);
   endtask
   task automatic attr_wr(input int x, input logic [7:0] v);
      op({1'b0, x[7:0], 1'b0}, pcuhi_pkg::CMD_ATTR_WR, v);
      attr_m[x] = v;
   endtask
   // subsystem read of one attribute byte in either bus mode
   task automatic sub_rd(input int x, input logic z);
      @(posedge CLK);
      sub_addr <= x[7:0];
      zmode <= z;
      sub_rd_n <= 0;
      repeat (3) @(posedge CLK);
      sub_rd_n <= 1;
      @(posedge CLK);
      chk(sub_data, 8'(attr_m[x]), "subsystem read");
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge CLK);
      RST_N <= 1;
      ticks = 0;
      for (int k = 0; k < 64; k++) begin
         repeat (3) @(posedge CLK);
         rclk <= ~rclk;
      end
      repeat (10) @(posedge CLK);
      chk(8'(ticks), 8'(64 / 2 / pcuhi_pkg::RCLK_DIV), "rx ticks");
      chk(8'(bus.ireq_n), 8'h01, "ready");
      sw_rd(3'h6, q);
      chk(q, 8'h00, "unmapped host reg");
      tdone("reset");
      for (int k = 0; k < 6; k++) begin
         i = $random(seed) & 8'h7F;
         d = 8'($random(seed));
         attr_wr(i, d);
         chk(8'(sub_irq), 8'h01, "subsystem irq");
         sub_rd(i, k[0]);
         chk(8'(sub_irq), 8'h00, "subsystem irq clear");
         op({1'b0, i[7:0], 1'b0}, pcuhi_pkg::CMD_ATTR_RD, 8'h00);
         chk(q, 8'(attr_m[i]), "attr read");
      end
      op({1'b0, i[7:0], 1'b1}, pcuhi_pkg::CMD_ATTR_WR, ~d);
      op({1'b0, i[7:0], 1'b1}, pcuhi_pkg::CMD_ATTR_RD, 8'h00);
      chk(q, pcuhi_pkg::IDLE_DATA, "odd byte read");
      sw_wr(pcuhi_pkg::H_CTRL, 8'h02);
      op({1'b0, i[7:0], 1'b0}, pcuhi_pkg::CMD_ATTR_RD, 8'h00);
      chk(q, pcuhi_pkg::IDLE_DATA, "second enable read");
      sw_wr(pcuhi_pkg::H_CTRL, 8'h00);
      op({1'b0, i[7:0], 1'b0}, pcuhi_pkg::CMD_ATTR_RD, 8'h00);
      chk(q, 8'(attr_m[i]), "even byte kept");
      tdone("attribute");
      op(10'h004, pcuhi_pkg::CMD_IO_RD, 8'h00);
      chk(8'(ack), 8'h00, "unconfigured io read");
      attr_wr(8'h80, 8'(pcuhi_pkg::CFG_CARD_IO));
      for (int k = 0; k < 8; k++) begin
         mcr_m = k << 2;
         op({7'h0, pcuhi_pkg::UR_MCR}, pcuhi_pkg::CMD_IO_WR, 8'(mcr_m));
         chk(8'(out_a_n), 8'(!(k[0] && !k[2])), "user out a");
         chk(8'(out_b_n), 8'(!(k[1] && !k[2])), "user out b");
         op({7'h0, pcuhi_pkg::UR_MCR}, pcuhi_pkg::CMD_IO_RD, 8'h00);
         chk(q, 8'(mcr_m), "mcr read");
         chk(8'(ack), 8'h01, "io read ack");
      end
      tdone("modem control");
      op({7'h0, pcuhi_pkg::UR_IER}, pcuhi_pkg::CMD_IO_WR, 8'h08);
      @(posedge CLK);
      ring_n <= 0;
      op({7'h0, pcuhi_pkg::UR_MSR}, pcuhi_pkg::CMD_IO_RD, 8'h00);
      chk(q, 8'h40, "ring level");
      chk(8'(bus.ireq_n), 8'h01, "no ring irq yet");
      @(posedge CLK);
      ring_n <= 1;
      repeat (6) @(posedge CLK);
      chk(8'(bus.ireq_n), 8'h00, "ring irq");
      op({7'h0, pcuhi_pkg::UR_MSR}, pcuhi_pkg::CMD_IO_RD, 8'h00);
      chk(q, 8'h04, "ring flag");
      chk(8'(bus.ireq_n), 8'h01, "ring irq cleared");
      op({7'h0, pcuhi_pkg::UR_MSR}, pcuhi_pkg::CMD_IO_RD, 8'h00);
      chk(q, 8'h00, "ring flag cleared");
      tdone("ring");
      attr_wr(8'h80, 8'(pcuhi_pkg::CFG_COM));
      scr_m = $random(seed) & 8'hFF;
      op({pcuhi_pkg::COM_BASE, pcuhi_pkg::UR_SCR}, pcuhi_pkg::CMD_IO_WR,
         8'(scr_m));
      op({pcuhi_pkg::COM_BASE, pcuhi_pkg::UR_SCR}, pcuhi_pkg::CMD_IO_RD,
         8'h00);
      chk(q, 8'(scr_m), "com scratch");
      op({7'h3E, pcuhi_pkg::UR_SCR}, pcuhi_pkg::CMD_IO_RD, 8'h00);
      chk(8'(ack), 8'h00, "com address mismatch");
      op({pcuhi_pkg::COM_BASE, pcuhi_pkg::UR_MCR}, pcuhi_pkg::CMD_IO_WR,
         8'h0C);
      chk(8'(out_a_n), 8'h00, "user out before reset");
      tdone("com port");
      sw_wr(pcuhi_pkg::H_CTRL, 8'h01);
      sw_wr(pcuhi_pkg::H_CTRL, 8'h00);
      // outputs change on the edge the task returns at; look one later
      @(posedge CLK);
      chk(8'(out_a_n), 8'h01, "user out after reset");
      chk(8'(out_b_n), 8'h01, "user out b after reset");
      repeat (2 * INIT_CYC + 4) @(posedge CLK);
      op({pcuhi_pkg::COM_BASE, pcuhi_pkg::UR_SCR}, pcuhi_pkg::CMD_IO_RD,
         8'h00);
      chk(8'(ack), 8'h00, "unconfigured after reset");
      tdone("card reset");
      summarize();
   end
endmodule
